// file: tcc_event_src.sv
// Far-side model of the event sources: capture pin, comparator, tick pin.
// Assumes the bench sets the wanted levels; pins follow off the clock grid.
`timescale 1ns/1ns
module tcc_event_src (
	// Requested levels
	input  wire logic cap_lvl,
	input  wire logic cmp_lvl,
	input  wire logic tick_lvl,
	// Pins
	output logic      capture_pin,
	output logic      comparator_output,
	output logic      external_tick_pin
);
	// ****************************************
	// Asynchronous pins
	// ****************************************
	assign #7 capture_pin       = cap_lvl;
	assign #7 comparator_output = cmp_lvl;
	assign #7 external_tick_pin = tick_lvl;
endmodule : tcc_event_src

// file: tcc_pkg.sv
// Constants, I/O locations and field positions of the 16-bit timer with capture.
// Assumes an 8-bit CPU I/O bus with one-cycle read and write strobes.
package tcc_pkg;

	// ****************************************
	// I/O locations
	// ****************************************
	localparam int          ADDR_W       = 4;
	localparam logic [3:0]  ADDR_CTRL_A  = 4'h0;
	localparam logic [3:0]  ADDR_CTRL_B  = 4'h1;
	localparam logic [3:0]  ADDR_CNT_LO  = 4'h2;
	localparam logic [3:0]  ADDR_CNT_HI  = 4'h3;
	localparam logic [3:0]  ADDR_CAP_LO  = 4'h4;
	localparam logic [3:0]  ADDR_CAP_HI  = 4'h5;
	localparam logic [3:0]  ADDR_FLAGS   = 4'h6;
	localparam logic [3:0]  ADDR_MASK    = 4'h7;
	localparam logic [3:0]  ADDR_CMP_CSR = 4'h8;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CA_WM_LSB = 0;
	localparam int CB_CS_LSB = 0;
	localparam int CB_WM_LSB = 3;
	localparam int CB_EDGE   = 6;
	localparam int CB_NF     = 7;
	localparam int FL_OVF    = 0;
	localparam int FL_CAP    = 5;
	localparam int CSR_CCS   = 2;

	// ****************************************
	// Reset and counter values
	// ****************************************
	localparam logic [7:0]  REG_RST = 8'h00;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] BOTTOM  = 16'h0000;
	localparam logic [15:0] MAX     = 16'hffff;
	localparam logic [15:0] TOP_8B  = 16'h00ff;
	localparam logic [15:0] TOP_9B  = 16'h01ff;
	localparam logic [15:0] TOP_10B = 16'h03ff;
	localparam int          FILT_LEN = 4;
	localparam logic [9:0]  PS_RST   = 10'h000;
	localparam logic [9:0]  PS_M8    = 10'h007;
	localparam logic [9:0]  PS_M64   = 10'h03f;
	localparam logic [9:0]  PS_M256  = 10'h0ff;
	localparam logic [9:0]  PS_M1024 = 10'h3ff;

	typedef enum logic [2:0] {CS_OFF, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024,
		CS_EXT_FALL, CS_EXT_RISE} tcc_cs_t;
	typedef enum logic {DIR_UP, DIR_DOWN} tcc_dir_t;

endpackage : tcc_pkg

// file: tcc_timer16.sv
// 16-bit up/down counter with shared high-byte latch and input capture unit.
// Assumes synchronous CPU strobes; trigger and tick pins are asynchronous.
// Contract
// - Clock select zero stops the counter
// - Each tick increments, decrements or clears counter
// - Top and bottom indications drive flag logic
// - Low byte access moves high byte via latch
// - CPU reaches counter whether ticking or not
// - CPU write beats count or clear
// - Split mode field selects sequence and overflow
// - Qualified edge copies counter into capture register
// - Capture flag set with the copy
// - Enabled flag requests interrupt, cleared on service
// - Writing one clears flag, zero keeps
// - Capture read low first, high via latch
// - Capture writable only in capture-top modes
// - Select bit switches trigger to comparator
// - Source change may capture; software clears flag
// - Trigger inputs synchronized like tick pin
// - Filter adds four cycles of delay
// - Capture disabled in capture-top modes
// - Filter output changes after four equal samples
// - Control B bit enables the filter
// - Bottom value is zero
`timescale 1ns/1ns
module tcc_timer16
	import tcc_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// CPU I/O bus
	input  wire logic [ADDR_W-1:0] io_addr,
	input  wire logic              io_wr,
	input  wire logic              io_rd,
	input  wire logic [7:0]        io_wdata,
	output logic      [7:0]        io_rdata,
	// Event sources
	input  wire logic              capture_pin,
	input  wire logic              comparator_output,
	input  wire logic              external_tick_pin,
	// Interrupt service
	input  wire logic              ack_capture,
	input  wire logic              ack_overflow,
	output logic                   irq_capture,
	output logic                   irq_overflow,
	// Sequence indications
	output logic                   at_top,
	output logic                   at_bottom
);

	// ****************************************
	// Mode decoding
	// ****************************************
	function automatic logic f_cap_top(input logic [3:0] m);
		f_cap_top = (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
	endfunction : f_cap_top
	function automatic logic f_dual(input logic [3:0] m);
		f_dual = (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hb);
	endfunction : f_dual
	function automatic logic [15:0] f_top(input logic [3:0] m, input logic [15:0] cap);
		case (m)
			4'h1, 4'h5: f_top = TOP_8B;
			4'h2, 4'h6: f_top = TOP_9B;
			4'h3, 4'h7: f_top = TOP_10B;
			4'h8, 4'ha, 4'hc, 4'he: f_top = cap;
			default: f_top = MAX;
		endcase
	endfunction : f_top

	// ****************************************
	// Input synchronizers
	// ****************************************
	logic [2:0] in_raw;
	logic [2:0] in_meta;
	logic [2:0] in_sync;
	assign in_raw = {external_tick_pin, comparator_output, capture_pin};
	generate
		for (genvar i = 0; i < 3; i++) begin : g_sync
			always_ff @(posedge clk) begin
				if (reset) begin
					in_meta[i] <= 1'b0;
					in_sync[i] <= 1'b0;
				end else begin
					in_meta[i] <= in_raw[i];
					in_sync[i] <= in_meta[i];
				end
			end
		end
	endgenerate

	// ****************************************
	// Prescaler, filter and edge detection
	// ****************************************
	logic [7:0]          ctrl_a;
	logic [7:0]          ctrl_b;
	logic [7:0]          cmp_csr;
	logic [9:0]          presc,    next_presc;
	logic                ext_prev, next_ext_prev;
	logic [FILT_LEN-1:0] filt_sh,  next_filt_sh;
	logic                filt_out, next_filt_out;
	logic                trig_prev, next_trig_prev;
	logic                trig_raw, trig, tick;
	logic [3:0]          mode;
	tcc_cs_t             cs;
	assign mode = {ctrl_b[CB_WM_LSB+1:CB_WM_LSB], ctrl_a[CA_WM_LSB+1:CA_WM_LSB]};
	assign cs   = tcc_cs_t'(ctrl_b[CB_CS_LSB+2:CB_CS_LSB]);
	assign trig_raw = cmp_csr[CSR_CCS] ? in_sync[1] : in_sync[0];
	assign trig = ctrl_b[CB_NF] ? filt_out : trig_raw;
	always_comb begin
		next_presc     = presc + 10'h001;
		next_ext_prev  = in_sync[2];
		next_filt_sh   = {filt_sh[FILT_LEN-2:0], trig_raw};
		next_filt_out  = (&next_filt_sh) ? 1'b1 : ((~|next_filt_sh) ? 1'b0 : filt_out);
		next_trig_prev = trig;
		case (cs)
			CS_OFF:      tick = 1'b0;
			CS_DIV1:     tick = 1'b1;
			CS_DIV8:     tick = (presc & PS_M8) == PS_M8;
			CS_DIV64:    tick = (presc & PS_M64) == PS_M64;
			CS_DIV256:   tick = (presc & PS_M256) == PS_M256;
			CS_DIV1024:  tick = presc == PS_M1024;
			CS_EXT_FALL: tick = ext_prev && !in_sync[2];
			CS_EXT_RISE: tick = !ext_prev && in_sync[2];
			default:     tick = 1'b0;
		endcase
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			presc     <= PS_RST;
			ext_prev  <= 1'b0;
			filt_sh   <= '0;
			filt_out  <= 1'b0;
			trig_prev <= 1'b0;
		end else begin
			presc     <= next_presc;
			ext_prev  <= next_ext_prev;
			filt_sh   <= next_filt_sh;
			filt_out  <= next_filt_out;
			trig_prev <= next_trig_prev;
		end
	end

	// ****************************************
	// Counter, capture and CPU registers
	// ****************************************
	logic [15:0] timer_count, next_timer_count;
	logic [15:0] capture_register, next_capture_register;
	logic [7:0]  temp, next_temp;
	logic [7:0]  next_ctrl_a, next_ctrl_b, next_cmp_csr;
	logic [7:0]  mask, next_mask;
	logic        overflow_flag, next_overflow_flag;
	logic        capture_flag, next_capture_flag;
	logic [7:0]  next_io_rdata;
	logic        next_irq_capture, next_irq_overflow;
	logic        next_at_top, next_at_bottom;
	tcc_dir_t    dir, next_dir;
	logic [15:0] cur_top;
	logic        edge_hit, cap_evt, ovf_evt;
	logic        wr_cnt_lo;
	logic        wr_flags;
	assign cur_top   = f_top(mode, capture_register);
	assign edge_hit  = ctrl_b[CB_EDGE] ? (trig && !trig_prev) : (!trig && trig_prev);
	assign cap_evt   = edge_hit && !f_cap_top(mode);
	assign wr_cnt_lo = io_wr && io_addr == ADDR_CNT_LO;
	assign wr_flags  = io_wr && io_addr == ADDR_FLAGS;
	always_comb begin
		next_timer_count      = timer_count;
		next_capture_register = capture_register;
		next_temp             = temp;
		next_ctrl_a           = ctrl_a;
		next_ctrl_b           = ctrl_b;
		next_cmp_csr          = cmp_csr;
		next_mask             = mask;
		next_dir              = dir;
		ovf_evt               = 1'b0;
		if (tick) begin
			if (f_dual(mode)) begin
				case (dir)
					DIR_UP: begin
						if (timer_count >= cur_top) begin
							next_dir         = DIR_DOWN;
							next_timer_count = timer_count - 16'h0001;
						end else
							next_timer_count = timer_count + 16'h0001;
					end
					DIR_DOWN: begin
						if (timer_count == BOTTOM) begin
							next_dir         = DIR_UP;
							ovf_evt          = 1'b1;
							next_timer_count = timer_count + 16'h0001;
						end else
							next_timer_count = timer_count - 16'h0001;
					end
					default: next_dir = DIR_UP;
				endcase
			end else begin
				next_dir = DIR_UP;
				if (timer_count == cur_top)
					next_timer_count = BOTTOM;
				else
					next_timer_count = timer_count + 16'h0001;
				ovf_evt = timer_count == MAX ||
					(timer_count == cur_top && mode != 4'h4 && mode != 4'hc);
			end
		end
		if (io_wr) begin
			case (io_addr)
				ADDR_CTRL_A:  next_ctrl_a  = io_wdata;
				ADDR_CTRL_B:  next_ctrl_b  = io_wdata;
				ADDR_CMP_CSR: next_cmp_csr = io_wdata;
				ADDR_MASK:    next_mask    = io_wdata;
				ADDR_CNT_HI, ADDR_CAP_HI: next_temp = io_wdata;
				ADDR_CNT_LO:  next_timer_count = {temp, io_wdata};
				ADDR_CAP_LO:  if (f_cap_top(mode)) next_capture_register = {temp, io_wdata};
				default: next_temp = temp;
			endcase
		end else if (io_rd && io_addr == ADDR_CNT_LO)
			next_temp = timer_count[15:8];
		else if (io_rd && io_addr == ADDR_CAP_LO)
			next_temp = capture_register[15:8];
		if (cap_evt)
			next_capture_register = timer_count;
		next_capture_flag  = cap_evt ||
			(capture_flag && !((wr_flags && io_wdata[FL_CAP]) || ack_capture));
		next_overflow_flag = ovf_evt ||
			(overflow_flag && !((wr_flags && io_wdata[FL_OVF]) || ack_overflow));
		next_irq_capture  = next_capture_flag && next_mask[FL_CAP];
		next_irq_overflow = next_overflow_flag && next_mask[FL_OVF];
		next_at_top       = next_timer_count == cur_top;
		next_at_bottom    = next_timer_count == BOTTOM;
		next_io_rdata     = 8'h00;
		if (io_rd) begin
			case (io_addr)
				ADDR_CTRL_A:  next_io_rdata = ctrl_a;
				ADDR_CTRL_B:  next_io_rdata = ctrl_b;
				ADDR_CMP_CSR: next_io_rdata = cmp_csr;
				ADDR_MASK:    next_io_rdata = mask;
				ADDR_FLAGS:   next_io_rdata = {2'b00, capture_flag, 4'h0, overflow_flag};
				ADDR_CNT_LO:  next_io_rdata = timer_count[7:0];
				ADDR_CAP_LO:  next_io_rdata = capture_register[7:0];
				ADDR_CNT_HI, ADDR_CAP_HI: next_io_rdata = temp;
				default:      next_io_rdata = 8'h00;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			timer_count      <= CNT_RST;
			capture_register <= CNT_RST;
			temp             <= REG_RST;
			ctrl_a           <= REG_RST;
			ctrl_b           <= REG_RST;
			cmp_csr          <= REG_RST;
			mask             <= REG_RST;
			dir              <= DIR_UP;
			overflow_flag    <= 1'b0;
			capture_flag     <= 1'b0;
			io_rdata         <= 8'h00;
			irq_capture      <= 1'b0;
			irq_overflow     <= 1'b0;
			at_top           <= 1'b0;
			at_bottom        <= 1'b1;
		end else begin
			timer_count      <= next_timer_count;
			capture_register <= next_capture_register;
			temp             <= next_temp;
			ctrl_a           <= next_ctrl_a;
			ctrl_b           <= next_ctrl_b;
			cmp_csr          <= next_cmp_csr;
			mask             <= next_mask;
			dir              <= next_dir;
			overflow_flag    <= next_overflow_flag;
			capture_flag     <= next_capture_flag;
			io_rdata         <= next_io_rdata;
			irq_capture      <= next_irq_capture;
			irq_overflow     <= next_irq_overflow;
			at_top           <= next_at_top;
			at_bottom        <= next_at_bottom;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_cnt_write;
		wr_cnt_lo |=> timer_count == {$past(temp), $past(io_wdata)};
	endproperty
	a_cnt_write: assert property (p_cnt_write) else $error("counter write lost");
	property p_stopped;
		(cs == CS_OFF && !wr_cnt_lo) |=> $stable(timer_count);
	endproperty
	a_stopped: assert property (p_stopped) else $error("counter moved while stopped");
	property p_inc;
		(tick && !wr_cnt_lo && !f_dual(mode) && timer_count != cur_top)
			|=> timer_count == $past(timer_count) + 16'h0001;
	endproperty
	a_inc: assert property (p_inc) else $error("counter did not increment");
	property p_capture;
		cap_evt |=> capture_flag && capture_register == $past(timer_count);
	endproperty
	a_capture: assert property (p_capture) else $error("capture copy or flag missing");
	property p_cap_off;
		(f_cap_top(mode) && !(io_wr && io_addr == ADDR_CAP_LO)) |=> $stable(capture_register);
	endproperty
	a_cap_off: assert property (p_cap_off) else $error("capture in capture-top mode");
	property p_flag_keep;
		(capture_flag && wr_flags && !io_wdata[FL_CAP] && !ack_capture) |=> capture_flag;
	endproperty
	a_flag_keep: assert property (p_flag_keep) else $error("zero write cleared flag");
	// Low read, one idle cycle, high read: the bus tasks' own spacing
	property p_latch_read;
		(io_rd && !io_wr && io_addr == ADDR_CNT_LO) ##1 (!io_wr && !io_rd)
			##1 (io_rd && !io_wr && io_addr == ADDR_CNT_HI)
			|=> io_rdata == $past(timer_count[15:8], 3);
	endproperty
	a_latch_read: assert property (p_latch_read) else $error("high byte not latched");
	property p_irq;
		(capture_flag && mask[FL_CAP]) |-> irq_capture;
	endproperty
	a_irq: assert property (p_irq) else $error("capture interrupt missing");
	property p_filter;
		$changed(filt_out) |-> filt_sh == {FILT_LEN{filt_out}};
	endproperty
	a_filter: assert property (p_filter) else $error("filter changed early");
	c_capture:  cover property (cap_evt ##1 irq_capture);
	c_wrap:     cover property (tick && timer_count == cur_top && !f_dual(mode));
	c_turn:     cover property (tick && f_dual(mode) && dir == DIR_DOWN && timer_count == BOTTOM);
	c_filtered: cover property (ctrl_b[CB_NF] && cap_evt);

endmodule : tcc_timer16

// file: tcc_timer16_test.sv
// Self-checking bench of the 16-bit timer with capture.
// Assumes tcc_pkg and the event source model are compiled first.
`timescale 1ns/1ns
module tcc_timer16_test
	import tcc_pkg::*;
;
	logic              clk;
	logic              reset;
	logic [ADDR_W-1:0] io_addr;
	logic              io_wr;
	logic              io_rd;
	logic [7:0]        io_wdata;
	logic [7:0]        io_rdata;
	logic              capture_pin;
	logic              comparator_output;
	logic              external_tick_pin;
	logic              ack_capture;
	logic              ack_overflow;
	logic              irq_capture;
	logic              irq_overflow;
	logic              at_top;
	logic              at_bottom;
	logic              cap_lvl;
	logic              cmp_lvl;
	logic              tick_lvl;
	logic [7:0]        b;
	logic [15:0]       v;
	int                bad_count;
	int                checked;
	int                n;
	int                divs [5] = '{1, 8, 64, 256, 1024};

	tcc_timer16 tcc_timer16_inst (.clk(clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .capture_pin(capture_pin),
		.comparator_output(comparator_output), .external_tick_pin(external_tick_pin),
		.ack_capture(ack_capture), .ack_overflow(ack_overflow), .irq_capture(irq_capture),
		.irq_overflow(irq_overflow), .at_top(at_top), .at_bottom(at_bottom));
	tcc_event_src tcc_event_src_inst (.cap_lvl(cap_lvl), .cmp_lvl(cmp_lvl), .tick_lvl(tick_lvl),
		.capture_pin(capture_pin), .comparator_output(comparator_output),
		.external_tick_pin(external_tick_pin));

	// ****************************************
	// Bus tasks and checking
	// ****************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge clk);
		io_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(negedge clk);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge clk);
		io_rd = 1'b0;
		d = io_rdata;
	endtask : rd
	task automatic wr16(input logic [3:0] lo, input logic [15:0] d);
		wr(lo + 4'h1, d[15:8]);
		wr(lo, d[7:0]);
	endtask : wr16
	task automatic rd16(input logic [3:0] lo, output logic [15:0] d);
		rd(lo, d[7:0]);
		rd(lo + 4'h1, d[15:8]);
	endtask : rd16
	task automatic flag_after(input int cyc, input logic [7:0] exp);
		repeat (cyc) @(negedge clk);
		rd(ADDR_FLAGS, b);
		chk(b, exp);
	endtask : flag_after
	task automatic wait_ind(input logic top, input int lim);
		n = 0;
		while (((top ? at_top : at_bottom) !== 1'b1) && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk(n < lim, 1'b1);
	endtask : wait_ind
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	// ****************************************
	// Clock, reset and watchdog
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#600000;
		bad_count++;
		wrap_up();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		{reset, io_addr, io_wr, io_rd, io_wdata} = {1'b1, 4'h0, 1'b0, 1'b0, 8'h00};
		{ack_capture, ack_overflow, cap_lvl, cmp_lvl, tick_lvl} = 5'h00;
		bad_count = 0;
		checked = 0;
		repeat (6) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		chk(at_bottom, 1'b1);
		wr16(ADDR_CNT_LO, 16'h01ff);
		repeat (5) @(negedge clk);
		rd16(ADDR_CNT_LO, v);
		chk(v, 16'h01ff);
		wr(ADDR_CNT_HI, 8'h00);
		wr(ADDR_CNT_LO, 8'h07);
		wr(ADDR_CAP_LO, 8'h09);
		rd16(ADDR_CNT_LO, v);
		chk(v, 16'h0007);
		rd16(ADDR_CAP_LO, v);
		chk(v, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			wr16(ADDR_CNT_LO, 16'h0000);
			wr(ADDR_CTRL_B, 8'(i + 1));
			repeat (2 * divs[i] - 1) @(posedge clk);
			wr(ADDR_CTRL_B, 8'h00);
			rd16(ADDR_CNT_LO, v);
			chk(v, 16'h0002);
		end
		for (int c = 6; c < 8; c++) begin
			wr16(ADDR_CNT_LO, 16'h0000);
			wr(ADDR_CTRL_B, 8'(c));
			repeat (3) begin
				tick_lvl = 1'b1;
				repeat (6) @(negedge clk);
				tick_lvl = 1'b0;
				repeat (6) @(negedge clk);
			end
			wr(ADDR_CTRL_B, 8'h00);
			rd16(ADDR_CNT_LO, v);
			chk(v, 16'h0003);
		end
		wr(ADDR_CTRL_B, 8'h01);
		wr16(ADDR_CNT_LO, 16'h1234);
		wr(ADDR_CTRL_B, 8'h00);
		rd16(ADDR_CNT_LO, v);
		chk(v, 16'h1236);
		wr16(ADDR_CNT_LO, 16'h0abc);
		wr(ADDR_MASK, 8'h21);
		wr(ADDR_CTRL_B, 8'h40);
		cap_lvl = 1'b1;
		flag_after(8, 8'h20);
		chk(irq_capture, 1'b1);
		rd16(ADDR_CAP_LO, v);
		chk(v, 16'h0abc);
		wr(ADDR_FLAGS, 8'h00);
		flag_after(0, 8'h20);
		wr(ADDR_FLAGS, 8'h20);
		flag_after(0, 8'h00);
		cap_lvl = 1'b0;
		flag_after(8, 8'h00);
		wr(ADDR_CTRL_B, 8'h00);
		cap_lvl = 1'b1;
		flag_after(8, 8'h00);
		cap_lvl = 1'b0;
		flag_after(8, 8'h20);
		@(negedge clk);
		ack_capture = 1'b1;
		@(negedge clk);
		ack_capture = 1'b0;
		chk(irq_capture, 1'b0);
		wr(ADDR_CMP_CSR, 8'h04);
		wr(ADDR_CTRL_B, 8'h40);
		wr(ADDR_FLAGS, 8'h20);
		cap_lvl = 1'b1;
		flag_after(8, 8'h00);
		cmp_lvl = 1'b1;
		flag_after(8, 8'h20);
		wr(ADDR_CMP_CSR, 8'h00);
		wr(ADDR_CTRL_B, 8'hc0);
		cap_lvl = 1'b0;
		repeat (10) @(negedge clk);
		wr(ADDR_FLAGS, 8'h20);
		cap_lvl = 1'b1;
		repeat (2) @(negedge clk);
		cap_lvl = 1'b0;
		flag_after(12, 8'h00);
		cap_lvl = 1'b1;
		repeat (6) @(negedge clk);
		chk(irq_capture, 1'b0);
		@(negedge clk);
		chk(irq_capture, 1'b1);
		wr(ADDR_FLAGS, 8'h21);
		wr(ADDR_CTRL_B, 8'h18);
		wr16(ADDR_CAP_LO, 16'h0010);
		rd16(ADDR_CAP_LO, v);
		chk(v, 16'h0010);
		cap_lvl = 1'b0;
		flag_after(8, 8'h00);
		wr16(ADDR_CNT_LO, 16'h000c);
		wr(ADDR_CTRL_B, 8'h19);
		wait_ind(1'b1, 20);
		wait_ind(1'b0, 5);
		wr(ADDR_CTRL_B, 8'h00);
		wr(ADDR_CTRL_A, 8'h01);
		wr16(ADDR_CNT_LO, 16'h00fd);
		wr(ADDR_FLAGS, 8'h01);
		wr(ADDR_CTRL_B, 8'h01);
		wait_ind(1'b1, 10);
		wait_ind(1'b0, 600);
		repeat (2) @(negedge clk);
		chk(irq_overflow, 1'b1);
		ack_overflow = 1'b1;
		@(negedge clk);
		ack_overflow = 1'b0;
		@(negedge clk);
		chk(irq_overflow, 1'b0);
		wrap_up();
	end
endmodule : tcc_timer16_test
